/* File: rtl/general_timer_and_free_counter.sv */
// General timer and 32-bit free-running counter behind an AXI4-Lite slave
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "timer_params.svh"

// How it works
// RULE_01: Bit 29 of timer_config runs the general timer when set and halts it when clear.
// RULE_02: When bit 29 falls from one to zero the preload field is forced to FFFFh.
// RULE_03: The preload field in bits 15:0 is the start value the timer counts down from.
// RULE_04: The timer raises a host interrupt each time it runs out, at the preload interval.
// RULE_05: timer_count shows the live count in bits 15:0 and resets to FFFFh.
// RULE_06: A 32-bit free counter starts at zero and adds one on every 25MHz tick.
// RULE_07: At its maximum the free counter wraps to zero and goes on with no flag.
// RULE_08: After reset the free counter may take up to 160ns to read as cleared.
// RULE_09: When the running timer passes zero it reloads the preload and sets a sticky flag.
module general_timer_and_free_counter #(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,      // 250 MHz clock
	input  wire logic              aresetn,   // Synchronous reset, active low
	input  wire logic [ADDR_W-1:0] awaddr,    // Write address
	input  wire logic              awvalid,   // Write address valid
	output logic                   awready,   // Write address ready
	input  wire logic [31:0]       wdata,     // Write data
	input  wire logic [3:0]        wstrb,     // Write byte enables
	input  wire logic              wvalid,    // Write data valid
	output logic                   wready,    // Write data ready
	output timer_pkg::resp_t       bresp,     // Write response
	output logic                   bvalid,    // Write response valid
	input  wire logic              bready,    // Write response ready
	input  wire logic [ADDR_W-1:0] araddr,    // Read address
	input  wire logic              arvalid,   // Read address valid
	output logic                   arready,   // Read address ready
	output logic [31:0]            rdata,     // Read data
	output timer_pkg::resp_t       rresp,     // Read response
	output logic                   rvalid,    // Read data valid
	input  wire logic              rready,    // Read data ready
	output logic                   timer_irq  // Timer interrupt, level
);
	import timer_pkg::*;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	cfg_t              cfg_reg;
	cfg_t              cfg_next;
	logic              en_prev_reg;
	logic [15:0]       count_reg;
	logic              flag_reg;
	logic [31:0]       free_reg;
	logic [3:0]        div_reg;
	logic              tick_reg;
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] waddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	resp_t             bresp_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	resp_t             rresp_reg;
	logic [31:0]       rdata_reg;

	// Write decode
	wire        wr_do      = aw_held_reg && w_held_reg && !bvalid_reg;
	wire        wr_cfg     = wr_do && (waddr_reg == `TIMER_CONFIG_ADDR);
	wire        wr_status  = wr_do && (waddr_reg == `TIMER_STATUS_ADDR);
	wire        wr_mapped  = wr_cfg || wr_status || (waddr_reg == `TIMER_COUNT_ADDR)
		|| (waddr_reg == `FREE_COUNT_ADDR);
	wire [31:0] cfg_word   = {2'h0, cfg_reg.en, 13'h0000, cfg_reg.preload};
	wire [31:0] cfg_merged = merge(cfg_word, wdata_reg, wstrb_reg);
	// Write-one-to-clear on the sticky flag
	wire        flag_clr   = wr_status && wstrb_reg[0] && wdata_reg[`TIMER_IRQ_BIT];

	// Timer events
	wire        start      = cfg_reg.en && !en_prev_reg;
	wire        step       = cfg_reg.en && en_prev_reg && tick_reg;
	wire        expire     = step && (count_reg == 16'h0000);

	// Read decode
	wire        rd_cfg     = (araddr == `TIMER_CONFIG_ADDR);
	wire        rd_count   = (araddr == `TIMER_COUNT_ADDR);
	wire        rd_status  = (araddr == `TIMER_STATUS_ADDR);
	wire        rd_free    = (araddr == `FREE_COUNT_ADDR);
	wire [31:0] rd_word    = rd_cfg    ? cfg_word :
		rd_count  ? {16'h0000, count_reg} :
		rd_status ? {31'h0000_0000, flag_reg} :
		rd_free   ? free_reg : 32'h0000_0000;
	wire        rd_hit     = rd_cfg || rd_count || rd_status || rd_free;

	always_comb
	begin
		cfg_next = cfg_reg;
		if (wr_cfg)
		begin
			cfg_next.en      = cfg_merged[`TIMER_EN_BIT];                   // [RULE_01]
			cfg_next.preload = cfg_merged[15:0];                            // [RULE_03]
		end
		// The forced value wins over a preload written in the same access
		if (cfg_reg.en && !cfg_next.en)
			cfg_next.preload = `TIMER_PRELOAD_RESET;                        // [RULE_02]
	end

	// One-cycle enable at 25MHz; also paces the timer so both share one time base
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_reg  <= 4'h0;
			tick_reg <= 1'b0;
			free_reg <= `FREE_COUNT_RESET;                                  // [RULE_08]
		end
		else
		begin
			div_reg  <= (div_reg == 4'(`FREE_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
			tick_reg <= (div_reg == 4'(`FREE_DIV - 1));
			if (tick_reg)
				free_reg <= free_reg + 32'h0000_0001;                       // [RULE_06] [RULE_07]
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg_reg     <= '{en: 1'b0, preload: `TIMER_PRELOAD_RESET};
			en_prev_reg <= 1'b0;
			count_reg   <= `TIMER_COUNT_RESET;
			flag_reg    <= 1'b0;
		end
		else
		begin
			cfg_reg     <= cfg_next;
			en_prev_reg <= cfg_reg.en;
			if (start)
				count_reg <= cfg_reg.preload;                               // [RULE_03]
			else if (expire)
				count_reg <= cfg_reg.preload;                               // [RULE_09]
			else if (step)
				count_reg <= count_reg - 16'h0001;                          // [RULE_01]
			// Set wins over a clear in the same cycle
			flag_reg    <= expire || (flag_reg && !flag_clr);               // [RULE_04] [RULE_09]
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			waddr_reg   <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready_reg)
			begin
				aw_held_reg <= 1'b1;
				waddr_reg   <= awaddr;
				awready_reg <= 1'b0;
			end
			if (wvalid && wready_reg)
			begin
				w_held_reg  <= 1'b1;
				wdata_reg   <= wdata;
				wstrb_reg   <= wstrb;
				wready_reg  <= 1'b0;
			end
			if (wr_do)
			begin
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
			end
			if (bvalid_reg && bready)
			begin
				bvalid_reg  <= 1'b0;
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `RESP_OKAY;
			rdata_reg   <= 32'h0000_0000;
		end
		else if (arvalid && arready_reg)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b1;
			rresp_reg   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			rdata_reg   <= rd_word;                                         // [RULE_05]
		end
		else if (rvalid_reg && rready)
		begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
		end
	end

	assign awready   = awready_reg;
	assign wready    = wready_reg;
	assign bvalid    = bvalid_reg;
	assign bresp     = bresp_reg;
	assign arready   = arready_reg;
	assign rvalid    = rvalid_reg;
	assign rresp     = rresp_reg;
	assign rdata     = rdata_reg;
	assign timer_irq = flag_reg;

	property p_timer_steps;
		@(posedge aclk) disable iff (!aresetn)
		(step && count_reg != 16'h0000 && !start) |=> count_reg == $past(count_reg) - 16'h0001;
	endproperty
	a_timer_steps: assert property (p_timer_steps) else $error("timer did not step"); // [RULE_01]

	property p_timer_halts;
		@(posedge aclk) disable iff (!aresetn)
		!cfg_reg.en |=> $stable(count_reg);
	endproperty
	a_timer_halts: assert property (p_timer_halts) else $error("halted timer moved"); // [RULE_01]

	property p_preload_forced;
		@(posedge aclk) disable iff (!aresetn)
		$fell(cfg_reg.en) |-> cfg_reg.preload == 16'hFFFF;
	endproperty
	a_preload_forced: assert property (p_preload_forced) else $error("preload not forced"); // [RULE_02]

	property p_start_loads;
		@(posedge aclk) disable iff (!aresetn)
		start |=> count_reg == $past(cfg_reg.preload);
	endproperty
	a_start_loads: assert property (p_start_loads) else $error("start did not load"); // [RULE_03]

	property p_expire_reloads;
		@(posedge aclk) disable iff (!aresetn)
		expire |=> (count_reg == $past(cfg_reg.preload)) && flag_reg && timer_irq;
	endproperty
	a_expire_reloads: assert property (p_expire_reloads) else $error("no reload or irq"); // [RULE_09]

	property p_flag_sticky;
		@(posedge aclk) disable iff (!aresetn)
		(flag_reg && !flag_clr) |=> flag_reg;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost"); // [RULE_04]

	property p_count_reset;
		@(posedge aclk)
		!aresetn |=> count_reg == 16'hFFFF;
	endproperty
	a_count_reset: assert property (p_count_reset) else $error("count reset wrong"); // [RULE_05]

	property p_free_step;
		@(posedge aclk) disable iff (!aresetn)
		tick_reg |=> free_reg == $past(free_reg) + 32'h0000_0001 ##1 !tick_reg [*8];
	endproperty
	a_free_step: assert property (p_free_step) else $error("free counter step"); // [RULE_06]

	property p_free_wrap;
		@(posedge aclk) disable iff (!aresetn)
		(tick_reg && free_reg == 32'hFFFF_FFFF) |=> free_reg == 32'h0000_0000;
	endproperty
	a_free_wrap: assert property (p_free_wrap) else $error("free counter wrap"); // [RULE_07]

	property p_free_cleared;
		@(posedge aclk)
		$rose(aresetn) |-> free_reg == 32'h0000_0000;
	endproperty
	a_free_cleared: assert property (p_free_cleared) else $error("free not cleared"); // [RULE_08]
endmodule // general_timer_and_free_counter

/* File: include/timer_params.svh */
// Register map, field positions, reset values and timing counts for the timer block
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define TIMER_CONFIG_ADDR     12'h08C
`define TIMER_COUNT_ADDR      12'h090
`define TIMER_STATUS_ADDR     12'h094
`define FREE_COUNT_ADDR       12'h09C

`define TIMER_EN_BIT          29
`define TIMER_IRQ_BIT         0
`define TIMER_PRELOAD_RESET   16'hFFFF
`define TIMER_COUNT_RESET     16'hFFFF
`define FREE_COUNT_RESET      32'h0000_0000

`define CLK_MHZ               250
`define FREE_MHZ              25
`define FREE_DIV              (`CLK_MHZ / `FREE_MHZ)
`define FREE_CLEAR_NS         160
`define FREE_CLEAR_CYCLES     ((`FREE_CLEAR_NS * `CLK_MHZ) / 1000)

`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

/* File: include/timer_pkg.sv */
// Types shared by the timer block
package timer_pkg;
	typedef logic [1:0] resp_t;

	typedef struct packed {
		logic        en;
		logic [15:0] preload;
	} cfg_t;
endpackage

/* File: dv/tb.sv */
// Self-checking bench for the general timer and free counter
`timescale 1ns/10ps
`include "timer_params.svh"
module tb;
	import timer_pkg::*;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, timer_irq;
	logic [31:0] wdata, rdata, d, e, seed;
	logic [3:0]  wstrb, strb;
	resp_t       bresp, rresp, r;
	int          errors, checked, cycles, t1, p, q;

	general_timer_and_free_counter #(.ADDR_W(12)) i_general_timer_and_free_counter (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.timer_irq(timer_irq));

	always #2 aclk = ~aclk;

	task stop_test;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Whole run needs under two thousand cycles; the ceiling leaves ample margin
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			$display("[ERR] %0t run did not finish", $time);
			stop_test;
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] cfg_exp(input logic en, input logic [15:0] pl);
		return {2'b00, en, 13'h0000, pl};
	endfunction

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Polls every edge so two waits measure the period to the exact cycle
	task wait_irq;
		q = 0;
		do
		begin
			@(posedge aclk);
			q++;
		end while (timer_irq !== 1'b1 && q < 1000);
	endtask

	initial
	begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{errors, checked, cycles} = '0;
		seed = 32'h0000_5A63;
		strb = 4'hF;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`TIMER_CONFIG_ADDR);
		chk(d, 32'h0000_FFFF);
		rd(`TIMER_COUNT_ADDR);
		chk(d, 32'h0000_FFFF);
		rd(12'h0A0);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		chk(d, 32'h0000_0000);
		wr(12'h0A0, 32'h0000_0001);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		rd(`FREE_COUNT_ADDR);
		e = d;
		t1 = $time;
		repeat (57) @(posedge aclk);
		rd(`FREE_COUNT_ADDR);
		q = d - e;
		p = ($time - t1) / (4 * `FREE_DIV);
		chk({31'h0, q >= p - 1 && q <= p + 1}, 32'h1);
		wr(`TIMER_COUNT_ADDR, 32'h0000_1234);
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
		rd(`TIMER_COUNT_ADDR);
		chk(d, 32'h0000_FFFF);
		// Only byte 0 enabled: the enable bit and the upper preload byte keep their old values
		strb = 4'h1;
		wr(`TIMER_CONFIG_ADDR, 32'hFFFF_FF5A);
		strb = 4'hF;
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
		rd(`TIMER_CONFIG_ADDR);
		chk(d, 32'h0000_FF5A);
		rd(`TIMER_COUNT_ADDR);
		chk(d, 32'h0000_FFFF);
		repeat (3)
		begin
			p = 2 + xs() % 14;
			// Reserved bits written as ones must read back as zero
			wr(`TIMER_CONFIG_ADDR, {3'b111, 13'h1FFF, p[15:0]});
			rd(`TIMER_CONFIG_ADDR);
			chk(d, cfg_exp(1'b1, p[15:0]));
			rd(`TIMER_COUNT_ADDR);
			chk({31'h0, d <= p}, 32'h1);
			wait_irq();
			chk({31'h0, timer_irq}, 32'h1);
			t1 = $time;
			wr(`TIMER_STATUS_ADDR, 32'h0000_0001);
			wait_irq();
			chk(($time - t1) / 4, (p + 1) * `FREE_DIV);
			e = xs();
			wr(`TIMER_CONFIG_ADDR, {16'h0000, e[15:0]});
			rd(`TIMER_CONFIG_ADDR);
			chk(d, cfg_exp(1'b0, 16'hFFFF));
			rd(`TIMER_COUNT_ADDR);
			e = d;
			repeat (30) @(posedge aclk);
			rd(`TIMER_COUNT_ADDR);
			chk(d, e);
			rd(`TIMER_STATUS_ADDR);
			chk(d, 32'h0000_0001);
			wr(`TIMER_STATUS_ADDR, 32'h0000_0001);
			@(posedge aclk);
			chk({31'h0, timer_irq}, 32'h0);
			rd(`TIMER_STATUS_ADDR);
			chk(d, 32'h0000_0000);
		end
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`FREE_COUNT_ADDR);
		chk({31'h0, d <= 3}, 32'h1);
		rd(`TIMER_COUNT_ADDR);
		chk(d, 32'h0000_FFFF);
		stop_test;
	end
endmodule // tb
